// >>> iocrs_pkg.sv
// Constants and types shared by the I/O cell register slice.
// Overview of operation
// - Each cell: pin buffer, five storage registers.
// - DDR uses both registers of each pair.
// - Input register has its own clock, enable.
// - Output and OE registers share clock, enable.
// - Shared clears; each register may ignore them.
// - Two input paths, combinational or registered, delayed.
// - Six periphery clock lines serve as sources.
// - Each cell selects its own control sources.
// - Four cells use thirty-two fabric connections.
// - Cell is input, output or bidirectional.
`default_nettype none
package iocrs_pkg;
   localparam int CELLS          = 4;
   localparam int CELL_LINKS     = 8;
   localparam int BLOCK_LINKS    = CELLS * CELL_LINKS;
   localparam int PERIPH_CLKS    = 6;
   localparam int CLK_SRCS       = PERIPH_CLKS + 2;
   localparam int CLK_SEL_W      = 3;
   localparam int CLK_SRC_LOCAL  = 0;
   localparam int CLK_SRC_PERIPH = 1;
   localparam int CLK_SRC_ROWCOL = CLK_SRCS - 1;
   localparam int REGS           = 5;
   localparam int REG_IN         = 0;
   localparam int REG_OUT_HI     = 1;
   localparam int REG_OUT_LO     = 2;
   localparam int REG_OE_HI      = 3;
   localparam int REG_OE_LO      = 4;
   localparam int PATHS          = 2;
   localparam int DLY_DEPTH      = 8;
   localparam int DLY_SEL_W      = 3;
   localparam int MODE_W         = 2;
   localparam logic REG_RST_VAL  = 1'b0;
   localparam logic SEL_LOCAL    = 1'b0;
   localparam logic [MODE_W-1:0] MODE_INPUT  = 2'h0;
   localparam logic [MODE_W-1:0] MODE_OUTPUT = 2'h1;
   localparam logic [MODE_W-1:0] MODE_BIDIR  = 2'h2;
endpackage
`default_nettype wire

// >>> iocrs_ctl_if.sv
// Control bundle carrying one clock domain's strobes and clears to cell registers.
`timescale 1ns/1ns
`default_nettype none
interface iocrs_ctl_if;
   logic rise;
   logic fall;
   logic ce;
   logic aclr;
   logic sclr;
   logic aclr_val;
   logic sclr_val;
   modport drv      (output rise, output fall, output ce, output aclr, output sclr, output aclr_val,
                     output sclr_val);
   modport reg_side (input rise, input fall, input ce, input aclr, input sclr, input aclr_val,
                     input sclr_val);
endinterface
`default_nettype wire

// >>> iocrs_clk_sel.sv
// Clock source selector turning a chosen slow clock line into edge enable pulses.
`timescale 1ns/1ns
`default_nettype none
module iocrs_clk_sel (
   input  wire logic                                 clock,
   input  wire logic                                 nrst,
   input  wire logic [iocrs_pkg::CLK_SRCS-1:0]       src,
   input  wire logic [iocrs_pkg::CLK_SEL_W-1:0]      sel,
   output logic                                      level,
   output logic                                      rise,
   output logic                                      fall
);
   logic prev_r;
   logic prev_nxt;

   always_comb begin
      level    = src[sel];
      rise     = level & ~prev_r;
      fall     = ~level & prev_r;
      prev_nxt = level;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end
endmodule // iocrs_clk_sel
`default_nettype wire

// >>> iocrs_reg.sv
// One cell storage register with shared clears and per-register ignore options.
`timescale 1ns/1ns
`default_nettype none
module iocrs_reg #(
   parameter bit FALL_EDGE = 1'b0
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   iocrs_ctl_if.reg_side     ctl,
   input  wire logic         d,
   input  wire logic         ign_aclr,
   input  wire logic         ign_sclr,
   output logic              q
);
   logic q_r;
   logic q_nxt;
   logic load;
   logic aclr_on;
   logic sclr_on;

   always_comb begin
      load    = FALL_EDGE ? ctl.fall : ctl.rise;
      aclr_on = ctl.aclr & ~ign_aclr;
      sclr_on = ctl.sclr & ~ign_sclr;
      q_nxt   = q_r;
      if (aclr_on) begin
         q_nxt = ctl.aclr_val;
      end else if (load && ctl.ce) begin
         q_nxt = sclr_on ? ctl.sclr_val : d;
      end
      q = aclr_on ? ctl.aclr_val : q_r;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         q_r <= iocrs_pkg::REG_RST_VAL;
      end else begin
         q_r <= q_nxt;
      end
   end
endmodule // iocrs_reg
`default_nettype wire

// >>> iocrs_io_block.sv
// Row I/O block of four I/O cells, each with its register slice and pin buffer controls.
`timescale 1ns/1ns
`default_nettype none
module iocrs_io_block (
   input  wire logic                                                           clock,
   input  wire logic                                                           nrst,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_data_hi,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_data_lo,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_oe,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_ce_in,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_ce_out,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_aclr,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_sclr,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_clk,
   input  wire logic                                                           rowcol_oe,
   input  wire logic                                                           rowcol_ce_in,
   input  wire logic                                                           rowcol_ce_out,
   input  wire logic                                                           rowcol_aclr,
   input  wire logic                                                           rowcol_sclr,
   input  wire logic                                                           rowcol_clk,
   input  wire logic [iocrs_pkg::PERIPH_CLKS-1:0]                              periph_clk,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    pin_in,
   output logic      [iocrs_pkg::CELLS-1:0]                                    pin_out,
   output logic      [iocrs_pkg::CELLS-1:0]                                    pin_oe,
   output logic      [iocrs_pkg::CELLS-1:0]                                    fabric_datain_a,
   output logic      [iocrs_pkg::CELLS-1:0]                                    fabric_datain_b,
   input  wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::MODE_W-1:0]             cfg_mode,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_ddr,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_oe_sel,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_ce_in_sel,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_ce_out_sel,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_aclr_sel,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_sclr_sel,
   input  wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::CLK_SEL_W-1:0]          cfg_clk_in_sel,
   input  wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::CLK_SEL_W-1:0]          cfg_clk_out_sel,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_aclr_preset,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_sclr_preset,
   input  wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::REGS-1:0]               cfg_ign_aclr,
   input  wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::REGS-1:0]               cfg_ign_sclr,
   input  wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_out_reg,
   input  wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::PATHS-1:0]              cfg_path_reg,
   input  wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::PATHS-1:0][iocrs_pkg::DLY_SEL_W-1:0] cfg_dly
);
   genvar c;
   genvar p;

   // Each cell takes its own share of the thirty-two fabric lines of the block.
   generate
      for (c = 0; c < iocrs_pkg::CELLS; c++) begin : g_cell
         iocrs_ctl_if in_ctl ();
         iocrs_ctl_if out_ctl ();
         logic [iocrs_pkg::CLK_SRCS-1:0] clk_src;
         logic                           in_level;
         logic                           in_rise;
         logic                           in_fall;
         logic                           out_level;
         logic                           out_rise;
         logic                           out_fall;
         logic                           oe_src;
         logic                           ce_in_src;
         logic                           ce_out_src;
         logic                           aclr_src;
         logic                           sclr_src;
         logic [iocrs_pkg::REGS-1:0]     q;
         logic                           drive_val;
         logic                           drive_en;

         // Clock candidates: local cluster routing, six periphery lines, row and column routing.
         always_comb begin
            clk_src                                 = '0;
            clk_src[iocrs_pkg::CLK_SRC_LOCAL]       = fabric_clk[c];
            clk_src[iocrs_pkg::CLK_SRC_PERIPH +: iocrs_pkg::PERIPH_CLKS] = periph_clk;
            clk_src[iocrs_pkg::CLK_SRC_ROWCOL]      = rowcol_clk;
         end

         // Per-cell control source choice between local cluster and row or column routing.
         always_comb begin
            oe_src     = (cfg_oe_sel[c] == iocrs_pkg::SEL_LOCAL) ? fabric_oe[c] : rowcol_oe;
            ce_in_src  = (cfg_ce_in_sel[c] == iocrs_pkg::SEL_LOCAL) ? fabric_ce_in[c] : rowcol_ce_in;
            ce_out_src = (cfg_ce_out_sel[c] == iocrs_pkg::SEL_LOCAL) ? fabric_ce_out[c] : rowcol_ce_out;
            aclr_src   = (cfg_aclr_sel[c] == iocrs_pkg::SEL_LOCAL) ? fabric_aclr[c] : rowcol_aclr;
            sclr_src   = (cfg_sclr_sel[c] == iocrs_pkg::SEL_LOCAL) ? fabric_sclr[c] : rowcol_sclr;
         end

         iocrs_clk_sel u_in_clk (
            .clock (clock),
            .nrst  (nrst),
            .src   (clk_src),
            .sel   (cfg_clk_in_sel[c]),
            .level (in_level),
            .rise  (in_rise),
            .fall  (in_fall)
         );

         iocrs_clk_sel u_out_clk (
            .clock (clock),
            .nrst  (nrst),
            .src   (clk_src),
            .sel   (cfg_clk_out_sel[c]),
            .level (out_level),
            .rise  (out_rise),
            .fall  (out_fall)
         );

         // Input domain has its own clock and enable; output and OE share one clock and one enable; all share the clears.
         always_comb begin
            in_ctl.rise      = in_rise;
            in_ctl.fall      = in_fall;
            in_ctl.ce        = ce_in_src;
            in_ctl.aclr      = aclr_src;
            in_ctl.sclr      = sclr_src;
            in_ctl.aclr_val  = cfg_aclr_preset[c];
            in_ctl.sclr_val  = cfg_sclr_preset[c];
            out_ctl.rise     = out_rise;
            out_ctl.fall     = out_fall;
            out_ctl.ce       = ce_out_src;
            out_ctl.aclr     = aclr_src;
            out_ctl.sclr     = sclr_src;
            out_ctl.aclr_val = cfg_aclr_preset[c];
            out_ctl.sclr_val = cfg_sclr_preset[c];
         end

         // The five storage registers of the cell.
         iocrs_reg #(.FALL_EDGE(1'b0)) u_in_reg (
            .clock    (clock),
            .nrst     (nrst),
            .ctl      (in_ctl),
            .d        (pin_in[c]),
            .ign_aclr (cfg_ign_aclr[c][iocrs_pkg::REG_IN]),
            .ign_sclr (cfg_ign_sclr[c][iocrs_pkg::REG_IN]),
            .q        (q[iocrs_pkg::REG_IN])
         );

         iocrs_reg #(.FALL_EDGE(1'b0)) u_out_hi (
            .clock    (clock),
            .nrst     (nrst),
            .ctl      (out_ctl),
            .d        (fabric_data_hi[c]),
            .ign_aclr (cfg_ign_aclr[c][iocrs_pkg::REG_OUT_HI]),
            .ign_sclr (cfg_ign_sclr[c][iocrs_pkg::REG_OUT_HI]),
            .q        (q[iocrs_pkg::REG_OUT_HI])
         );

         iocrs_reg #(.FALL_EDGE(1'b1)) u_out_lo (
            .clock    (clock),
            .nrst     (nrst),
            .ctl      (out_ctl),
            .d        (fabric_data_lo[c]),
            .ign_aclr (cfg_ign_aclr[c][iocrs_pkg::REG_OUT_LO]),
            .ign_sclr (cfg_ign_sclr[c][iocrs_pkg::REG_OUT_LO]),
            .q        (q[iocrs_pkg::REG_OUT_LO])
         );

         iocrs_reg #(.FALL_EDGE(1'b0)) u_oe_hi (
            .clock    (clock),
            .nrst     (nrst),
            .ctl      (out_ctl),
            .d        (oe_src),
            .ign_aclr (cfg_ign_aclr[c][iocrs_pkg::REG_OE_HI]),
            .ign_sclr (cfg_ign_sclr[c][iocrs_pkg::REG_OE_HI]),
            .q        (q[iocrs_pkg::REG_OE_HI])
         );

         iocrs_reg #(.FALL_EDGE(1'b1)) u_oe_lo (
            .clock    (clock),
            .nrst     (nrst),
            .ctl      (out_ctl),
            .d        (oe_src),
            .ign_aclr (cfg_ign_aclr[c][iocrs_pkg::REG_OE_LO]),
            .ign_sclr (cfg_ign_sclr[c][iocrs_pkg::REG_OE_LO]),
            .q        (q[iocrs_pkg::REG_OE_LO])
         );

         // Pin driver: DDR picks the high register while the output clock is high.
         always_comb begin
            if (!cfg_out_reg[c]) begin
               drive_val = fabric_data_hi[c];
               drive_en  = oe_src;
            end else if (cfg_ddr[c] && !out_level) begin
               drive_val = q[iocrs_pkg::REG_OUT_LO];
               drive_en  = q[iocrs_pkg::REG_OE_LO];
            end else begin
               drive_val = q[iocrs_pkg::REG_OUT_HI];
               drive_en  = q[iocrs_pkg::REG_OE_HI];
            end
            case (cfg_mode[c])
               iocrs_pkg::MODE_INPUT: begin
                  pin_oe[c] = 1'b0;
               end
               iocrs_pkg::MODE_OUTPUT: begin
                  pin_oe[c] = 1'b1;
               end
               iocrs_pkg::MODE_BIDIR: begin
                  pin_oe[c] = drive_en;
               end
               default: begin
                  pin_oe[c] = 1'b0;
               end
            endcase
            pin_out[c] = (cfg_mode[c] == iocrs_pkg::MODE_INPUT) ? 1'b0 : drive_val;
         end

         // Two input paths into the fabric, each with its own delay chain.
         for (p = 0; p < iocrs_pkg::PATHS; p++) begin : g_path
            logic [iocrs_pkg::DLY_DEPTH-1:0] dly_r;
            logic [iocrs_pkg::DLY_DEPTH-1:0] dly_nxt;
            logic                            path_src;
            logic                            path_out;

            always_comb begin
               path_src = cfg_path_reg[c][p] ? q[iocrs_pkg::REG_IN] : pin_in[c];
               dly_nxt  = {dly_r[iocrs_pkg::DLY_DEPTH-2:0], path_src};
               path_out = (cfg_dly[c][p] == '0) ? path_src : dly_r[cfg_dly[c][p] - 1'b1];
            end

            always_ff @(posedge clock or negedge nrst) begin
               if (!nrst) begin
                  dly_r <= '0;
                  // Shift register models the programmable delay taps.
               end else begin
                  dly_r <= dly_nxt;
               end
            end

            if (p == 0) begin : g_a
               assign fabric_datain_a[c] = path_out;
            end else begin : g_b
               assign fabric_datain_b[c] = path_out;
            end
         end
      end
   endgenerate
endmodule // iocrs_io_block
`default_nettype wire

// >>> iocrs_pin_model.sv
// Board device model that shares the four pins with the I/O cells.
`timescale 1ns/1ns
`default_nettype none
module iocrs_pin_model (
   input  wire logic [iocrs_pkg::CELLS-1:0] pin_out,
   input  wire logic [iocrs_pkg::CELLS-1:0] pin_oe,
   input  wire logic [iocrs_pkg::CELLS-1:0] ext_val,
   output logic      [iocrs_pkg::CELLS-1:0] pin_in
);
   // The wire follows the cell while it drives and the board value otherwise.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // iocrs_pin_model
`default_nettype wire

// >>> iocrs_properties.sv
// Concurrent checks on the ports of the I/O cell register slice.
`timescale 1ns/1ns
`default_nettype none
module iocrs_properties (
   input wire logic                                                           clock,
   input wire logic                                                           nrst,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_data_hi,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_data_lo,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_ce_in,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_ce_out,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_aclr,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_sclr,
   input wire logic [iocrs_pkg::PERIPH_CLKS-1:0]                              periph_clk,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    pin_in,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    pin_out,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    pin_oe,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_datain_a,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    fabric_datain_b,
   input wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::MODE_W-1:0]             cfg_mode,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_ddr,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_ce_in_sel,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_ce_out_sel,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_aclr_sel,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_sclr_sel,
   input wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::CLK_SEL_W-1:0]          cfg_clk_in_sel,
   input wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::CLK_SEL_W-1:0]          cfg_clk_out_sel,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_aclr_preset,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_sclr_preset,
   input wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::REGS-1:0]               cfg_ign_aclr,
   input wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::REGS-1:0]               cfg_ign_sclr,
   input wire logic [iocrs_pkg::CELLS-1:0]                                    cfg_out_reg,
   input wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::PATHS-1:0]              cfg_path_reg,
   input wire logic [iocrs_pkg::CELLS-1:0][iocrs_pkg::PATHS-1:0][iocrs_pkg::DLY_SEL_W-1:0] cfg_dly
);
   wire c0_sdr = cfg_mode[0] == 2'h1 && !cfg_ddr[0] && cfg_out_reg[0] && cfg_clk_out_sel[0] == 3'h1 &&
                 !cfg_ce_out_sel[0] && !cfg_aclr_sel[0] && !cfg_sclr_sel[0];
   wire clr0   = fabric_aclr[0] && !cfg_ign_aclr[0][1];
   wire sclr0  = fabric_sclr[0] && !cfg_ign_sclr[0][1];
   wire c1_cap = cfg_clk_in_sel[1] == 3'h2 && !cfg_ce_in_sel[1] && !cfg_aclr_sel[1] && !cfg_sclr_sel[1] &&
                 cfg_path_reg[1][0] && cfg_dly[1][0] == 3'h0 && fabric_ce_in[1] && !fabric_aclr[1] && !fabric_sclr[1];
   wire c2_ddr = cfg_mode[2] == 2'h1 && cfg_ddr[2] && cfg_out_reg[2] && cfg_clk_out_sel[2] == 3'h1 &&
                 !cfg_ce_out_sel[2] && !cfg_aclr_sel[2] && !cfg_sclr_sel[2] && fabric_ce_out[2] &&
                 !fabric_aclr[2] && !fabric_sclr[2];
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   chk_load_edge: assert property (c0_sdr && $rose(periph_clk[0]) && fabric_ce_out[0] && !clr0 && !sclr0
      |=> !c0_sdr || clr0 || pin_out[0] == $past(fabric_data_hi[0])) else $error("output register load wrong");
   chk_sclr_value: assert property (c0_sdr && $rose(periph_clk[0]) && fabric_ce_out[0] && !clr0 && sclr0
      |=> !c0_sdr || clr0 || pin_out[0] == $past(cfg_sclr_preset[0])) else $error("sync clear value wrong");
   chk_hold_between: assert property (c0_sdr && !clr0 && !($rose(periph_clk[0]) && fabric_ce_out[0])
      |=> !c0_sdr || clr0 || $stable(pin_out[0])) else $error("output register changed without edge");
   chk_aclr_now: assert property (c0_sdr && clr0 |-> pin_out[0] == cfg_aclr_preset[0])
      else $error("async clear not immediate");
   chk_oe_aclr: assert property (cfg_mode[1] == 2'h2 && cfg_out_reg[1] && !cfg_ddr[1] && !cfg_aclr_sel[1] &&
      fabric_aclr[1] && !cfg_ign_aclr[1][3] |-> pin_oe[1] == cfg_aclr_preset[1]) else $error("enable clear wrong");
   chk_bypass_out: assert property (cfg_mode[0] == 2'h1 && !cfg_out_reg[0] |-> pin_out[0] == fabric_data_hi[0])
      else $error("bypass output wrong");
   chk_input_quiet: assert property (cfg_mode[3] == 2'h0 |-> !pin_oe[3] && !pin_out[3])
      else $error("input mode drives pin");
   chk_mode_drive: assert property (cfg_mode[3] != 2'h2 |-> pin_oe[3] == (cfg_mode[3] == 2'h1))
      else $error("pin enable wrong for mode");
   chk_comb_path: assert property (!cfg_path_reg[3][1] && cfg_dly[3][1] == 3'h0
      |-> fabric_datain_b[3] == pin_in[3]) else $error("combinational path wrong");
   chk_delay_three: assert property (cfg_dly[3][0] == 3'h3 && $past(cfg_dly[3][0], 3) == 3'h3 &&
      !cfg_path_reg[3][0] && $past(cfg_path_reg[3][0], 3) == 1'b0 && $past(nrst) && $past(nrst, 2) && $past(nrst, 3)
      |-> fabric_datain_a[3] == $past(pin_in[3], 3)) else $error("delay chain wrong");
   chk_input_capture: assert property (c1_cap && $rose(periph_clk[1])
      |=> fabric_aclr[1] || fabric_datain_a[1] == $past(pin_in[1])) else $error("input register capture wrong");
   chk_ddr_fall: assert property (c2_ddr && $past(nrst) && $fell(periph_clk[0])
      |=> periph_clk[0] || fabric_aclr[2] || pin_out[2] == $past(fabric_data_lo[2])) else $error("low half wrong");
   cov_sclr_load: cover property (c0_sdr && $rose(periph_clk[0]) && fabric_ce_out[0] && sclr0);
   cov_ddr_fall: cover property (c2_ddr && $fell(periph_clk[0]));
   cov_capture: cover property (c1_cap && $rose(periph_clk[1]));
endmodule // iocrs_properties
bind iocrs_io_block iocrs_properties iocrs_properties_inst (.*);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the I/O cell register slice.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int C = iocrs_pkg::CELLS;
   logic                         clock, nrst, rowcol_oe, rowcol_ce_in, rowcol_ce_out, rowcol_aclr, rowcol_sclr, rowcol_clk;
   logic [C-1:0]                 fabric_data_hi, fabric_data_lo, fabric_oe, fabric_ce_in, fabric_ce_out, fabric_clk;
   logic [C-1:0]                 fabric_aclr, fabric_sclr, pin_in, pin_out, pin_oe, fabric_datain_a, fabric_datain_b;
   logic [C-1:0]                 ext_val, cfg_ddr, cfg_oe_sel, cfg_ce_in_sel, cfg_ce_out_sel, cfg_aclr_sel, cfg_sclr_sel;
   logic [C-1:0]                 cfg_aclr_preset, cfg_sclr_preset, cfg_out_reg;
   logic [5:0]                   periph_clk;
   logic [C-1:0][1:0]            cfg_mode, cfg_path_reg;
   logic [C-1:0][2:0]            cfg_clk_in_sel, cfg_clk_out_sel;
   logic [C-1:0][4:0]            cfg_ign_aclr, cfg_ign_sclr;
   logic [C-1:0][1:0][2:0]       cfg_dly;
   logic [31:0]                  r, r2;
   logic                         hv, lv, hist[$];
   int                           n_errors, n_tests, seed = 32'h35E4;
   iocrs_io_block iocrs_io_block_inst (.*);
   iocrs_pin_model iocrs_pin_model_inst (.*);
   task check(input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %b expected %b", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task edge_clk(input int i, input logic v);
      @(posedge clock) periph_clk[i] <= v;
      repeat (3) @(posedge clock);
      #1;
   endtask
   function logic exp_oe(input logic [1:0] m, input logic o);
      return m == 2'h1 ? 1'b1 : (m == 2'h2 ? o : 1'b0);
   endfunction
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
   initial begin
      nrst = 1'b0;
      {fabric_data_hi, fabric_data_lo, fabric_oe, fabric_ce_in, fabric_ce_out, fabric_aclr, fabric_sclr, fabric_clk,
       rowcol_oe, rowcol_ce_in, rowcol_ce_out, rowcol_aclr, rowcol_sclr, rowcol_clk, periph_clk, ext_val, cfg_oe_sel,
       cfg_ce_in_sel, cfg_ce_out_sel, cfg_aclr_sel, cfg_sclr_sel, cfg_aclr_preset, cfg_sclr_preset, cfg_ign_aclr,
       cfg_ign_sclr, cfg_dly} = '0;
      cfg_mode = {2'h0, 2'h1, 2'h2, 2'h1};
      cfg_out_reg = 4'h7;
      cfg_ddr = 4'h4;
      cfg_clk_out_sel = {3'h1, 3'h1, 3'h1, 3'h1};
      cfg_clk_in_sel = {3'h0, 3'h0, 3'h2, 3'h0};
      cfg_path_reg = {2'h0, 2'h0, 2'h1, 2'h0};
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      #1;
      check(pin_out[0], 1'b0);
      check(pin_oe[0], 1'b1);
      @(posedge clock) {fabric_data_hi[0], fabric_ce_out[0]} <= 2'h3;
      edge_clk(0, 1'b1);
      check(pin_out[0], 1'b1);
      @(posedge clock) {fabric_data_hi[0], fabric_ce_out[0]} <= 2'h0;
      edge_clk(0, 1'b0);
      edge_clk(0, 1'b1);
      check(pin_out[0], 1'b1);
      @(posedge clock) {fabric_data_hi[0], fabric_ce_out[0], fabric_sclr[0]} <= 3'h7;
      edge_clk(0, 1'b0);
      edge_clk(0, 1'b1);
      check(pin_out[0], 1'b0);
      @(posedge clock) cfg_ign_sclr[0][1] <= 1'b1;
      edge_clk(0, 1'b0);
      edge_clk(0, 1'b1);
      check(pin_out[0], 1'b1);
      @(posedge clock) fabric_aclr[0] <= 1'b1;
      #1;
      check(pin_out[0], 1'b0);
      @(posedge clock) cfg_ign_aclr[0][1] <= 1'b1;
      edge_clk(0, 1'b0);
      edge_clk(0, 1'b1);
      check(pin_out[0], 1'b1);
      @(posedge clock) {fabric_aclr[0], fabric_sclr[0], cfg_ign_aclr, cfg_ign_sclr, cfg_out_reg[0]} <= '0;
      @(posedge clock) fabric_data_hi[0] <= 1'b0;
      #1;
      check(pin_out[0], 1'b0);
      @(posedge clock) {cfg_out_reg[0], fabric_ce_out[2]} <= 2'h3;
      for (int k = 0; k < 4; k++) begin
         {hv, lv} = $random(seed);
         @(posedge clock) {fabric_data_hi[2], fabric_data_lo[2]} <= {hv, lv};
         edge_clk(0, 1'b0);
         check(pin_out[2], lv);
         edge_clk(0, 1'b1);
         check(pin_out[2], hv);
      end
      for (int k = 0; k < 4; k++) begin
         hv = $random(seed);
         @(posedge clock) {ext_val[1], fabric_ce_in[1]} <= {hv, 1'b1};
         edge_clk(1, 1'b1);
         check(fabric_datain_a[1], hv);
         edge_clk(1, 1'b0);
      end
      @(posedge clock) {fabric_oe[1], fabric_ce_out[1], fabric_data_hi[1], ext_val[1]} <= 4'hE;
      edge_clk(0, 1'b0);
      edge_clk(0, 1'b1);
      check(pin_oe[1], 1'b1);
      edge_clk(1, 1'b1);
      check(fabric_datain_a[1], 1'b1);
      for (int t = 0; t < 8; t++) begin
         @(posedge clock) cfg_dly[3][0] <= t[2:0];
         for (int k = 0; k < 60; k++) begin
            r = $random(seed);
            r2 = $random(seed);
            @(posedge clock);
            {fabric_data_hi, fabric_data_lo, fabric_ce_out, fabric_ce_in} <= r[15:0];
            {rowcol_oe, rowcol_ce_in, rowcol_ce_out, rowcol_aclr, rowcol_sclr, rowcol_clk, fabric_clk} <= r2[9:0];
            fabric_aclr <= r[19:16] & r[23:20] & r[27:24];
            fabric_sclr <= r[31:28] & r[23:20];
            ext_val <= r2[13:10];
            {cfg_aclr_preset, cfg_sclr_preset} <= r2[7:0] ^ r[31:24];
            {cfg_ign_aclr[1], cfg_ign_aclr[0], cfg_ign_sclr[0]} <= r2[28:14];
            if (k % 4 == 0) periph_clk <= r2[31:26];
            #1;
            hist.push_front(pin_in[3]);
            if (hist.size() > 8) void'(hist.pop_back());
            if (k > 9) check(fabric_datain_a[3], hist[t]);
         end
      end
      @(posedge clock) {cfg_out_reg[3], cfg_oe_sel[3]} <= 2'h1;
      for (int m = 0; m < 4; m++) begin
         @(posedge clock) {cfg_mode[3], rowcol_oe} <= {m[1:0], ~rowcol_oe};
         #1;
         check(pin_oe[3], exp_oe(m[1:0], rowcol_oe));
      end
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
